// File: design/pldr_diag_regs.sv
// link diagnostics read-out registers behind an Avalon-MM slave
//
// Local design decision: register access over Avalon-MM.
`include "pldr_cfg.svh"
module pldr_diag_regs #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [DATA_W/8-1:0] avs_byteenable,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire pldr_pkg::pldr_len_s lenIn,
	input wire logic dspAck,
	input wire pldr_pkg::pldr_dsp_s dspVal,
	output logic dspReq
);
	localparam int IDX_W = ADDR_W - `PLDR_IDX_LSB;

	if (ADDR_W < 8) begin : g_addr_chk
		$error("address too narrow for the register map");
	end
	if (DATA_W != 32) begin : g_data_chk
		$error("only a 32-bit data bus is served");
	end

	// bus state
	logic ackQ;
	logic next_ackQ;
	logic [DATA_W-1:0] next_readdata;

	// register state
	logic [`PLDR_PAGE_W-1:0] register_page_selector;
	logic [`PLDR_PAGE_W-1:0] next_register_page_selector;
	logic selCtrl;
	logic next_selCtrl;

	// decode
	logic req;
	logic accept;
	logic [IDX_W-1:0] wordIdx;
	logic hitPage;
	logic hitLen;
	logic hitFreq;
	logic diagOpen;
	logic beLow;
	logic beHigh;
	logic wrSel;
	logic start;

	// sub-block results
	logic [7:0] lenMeters;
	logic [7:0] freqField;
	logic sampBusy;

	pldr_len_qual u_len (
		.core_clk(core_clk),
		.rst(rst),
		.lenIn(lenIn),
		.meters(lenMeters)
	);

	pldr_sample_ctrl u_samp (
		.core_clk(core_clk),
		.rst(rst),
		.start(start),
		.selCtrl(wrSel),
		.dspAck(dspAck),
		.dspVal(dspVal),
		.dspReq(dspReq),
		.busy(sampBusy),
		.sample(freqField)
	);

	// every access takes exactly one wait cycle: data is prepared on the
	// first edge and the access completes on the second
	assign req = avs_read || avs_write;
	assign avs_waitrequest = req && !ackQ;
	assign accept = req && ackQ;

	assign wordIdx = avs_address[ADDR_W-1:`PLDR_IDX_LSB];
	assign hitPage = (wordIdx == IDX_W'(`PLDR_IDX_REGISTER_PAGE_SELECTOR));
	assign hitLen = (wordIdx == IDX_W'(`PLDR_IDX_LEN));
	assign hitFreq = (wordIdx == IDX_W'(`PLDR_IDX_FREQ));
	assign diagOpen = (register_page_selector == `PLDR_PAGE_DIAG); // R1
	assign beLow = avs_byteenable[`PLDR_BE_LOW];
	assign beHigh = avs_byteenable[`PLDR_BE_HIGH];

	// the select bit written together with the request takes effect at once
	assign wrSel = beHigh ? avs_writedata[`PLDR_BIT_SELCTL] : selCtrl; // R7

	// a request while a sample is still in flight is dropped
	assign start = accept && avs_write && diagOpen && hitFreq && beHigh
		&& avs_writedata[`PLDR_BIT_SAMPLE] && !sampBusy; // R6 R12

	always_comb begin
		next_ackQ = req && !ackQ;
	end

	always_comb begin
		next_readdata = avs_readdata;
		if (avs_read && !ackQ) begin
			next_readdata = '0; // R5
			if (hitPage) begin
				next_readdata[`PLDR_PAGE_W-1:0] = register_page_selector;
			end else if (hitLen && diagOpen) begin // R1
				next_readdata[`PLDR_FIELD_W-1:0] = lenMeters; // R3
			end else if (hitFreq && diagOpen) begin // R1
				// the request bit stays zero in the word
				next_readdata[`PLDR_BIT_SELCTL] = selCtrl; // R8
				next_readdata[`PLDR_FIELD_W-1:0] = freqField; // R9 R10
			end
		end
	end

	always_comb begin
		next_register_page_selector = register_page_selector;
		next_selCtrl = selCtrl;
		if (accept && avs_write) begin
			if (hitPage && beLow) begin
				next_register_page_selector = avs_writedata[`PLDR_PAGE_W-1:0];
			end
			if (hitFreq && diagOpen && beHigh) begin // R1
				next_selCtrl = avs_writedata[`PLDR_BIT_SELCTL]; // R7
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ackQ <= 1'b0;
			avs_readdata <= '0;
		end else begin
			ackQ <= next_ackQ;
			avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			register_page_selector <= `PLDR_RST_PAGE;
			selCtrl <= 1'b0;
		end else begin
			register_page_selector <= next_register_page_selector;
			selCtrl <= next_selCtrl;
		end
	end

	a_wait_one: assert property (@(posedge core_clk) disable iff (rst)
		req && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait cycle");

	a_page_gate: assert property (@(posedge core_clk) disable iff (rst) // R1
		avs_read && !ackQ && (hitLen || hitFreq) && !diagOpen
		|=> avs_readdata == '0)
		else $error("diagnostics register visible outside its page");

	a_sample_zero: assert property (@(posedge core_clk) disable iff (rst) // R8
		!avs_readdata[`PLDR_BIT_SAMPLE])
		else $error("sample request bit read back as one");

	a_resv_zero: assert property (@(posedge core_clk) disable iff (rst) // R5
		avs_read && !ackQ && diagOpen && (hitLen || hitFreq)
		|=> avs_readdata[DATA_W-1:`PLDR_BIT_SELCTL+1] == '0
		&& (!$past(hitLen) || !avs_readdata[`PLDR_BIT_SELCTL]))
		else $error("reserved bits not zero");

	a_start_req: assert property (@(posedge core_clk) disable iff (rst) // R12
		start |=> dspReq ##1 !dspReq)
		else $error("write of request bit gave no single processor request");

	a_len_read: assert property (@(posedge core_clk) disable iff (rst) // R3
		avs_read && !ackQ && hitLen && diagOpen
		|=> avs_readdata[`PLDR_FIELD_W-1:0] == $past(lenMeters))
		else $error("length read does not match estimate");

	a_sel_write: assert property (@(posedge core_clk) disable iff (rst) // R7
		accept && avs_write && hitFreq && diagOpen && beHigh
		|=> selCtrl == $past(avs_writedata[`PLDR_BIT_SELCTL]))
		else $error("select bit not stored on write");

	a_unknown_len: assert property (@(posedge core_clk) disable iff (rst) // R4
		avs_read && !ackQ && hitLen && diagOpen && !lenIn.linkUp
		&& $past(!lenIn.linkUp)
		|=> avs_readdata[`PLDR_FIELD_W-1:0] == `PLDR_LEN_UNKNOWN)
		else $error("length without link not all-ones");

	// select in force for the request in flight, kept only for the load checks
	logic reqSel;
	logic next_reqSel;

	always_comb begin
		next_reqSel = reqSel;
		if (start) begin
			next_reqSel = wrSel;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reqSel <= 1'b0;
		end else begin
			reqSel <= next_reqSel;
		end
	end

	// bus and register map
	a_ack_pulse: assert property (@(posedge core_clk) disable iff (rst)
		ackQ |=> !ackQ)
		else $error("acknowledge held for more than one cycle");

	a_read_stand: assert property (@(posedge core_clk) disable iff (rst)
		!(avs_read && !ackQ) |=> $stable(avs_readdata))
		else $error("read data changed without a new read");

	a_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst) // R5
		avs_read && !ackQ && !hitPage && !hitLen && !hitFreq |=> avs_readdata == '0)
		else $error("unmapped register read not zero");

	a_page_write: assert property (@(posedge core_clk) disable iff (rst) // R1
		accept && avs_write && hitPage && beLow
		|=> register_page_selector == $past(avs_writedata[`PLDR_PAGE_W-1:0]))
		else $error("page select not stored on write");

	a_page_hold: assert property (@(posedge core_clk) disable iff (rst) // R1
		!(accept && avs_write && hitPage && beLow) |=> $stable(register_page_selector))
		else $error("page select changed without a write");

	a_page_read: assert property (@(posedge core_clk) disable iff (rst) // R1
		avs_read && !ackQ && hitPage
		|=> avs_readdata[`PLDR_PAGE_W-1:0] == $past(register_page_selector))
		else $error("page select read back wrong");

	a_page_upper: assert property (@(posedge core_clk) disable iff (rst)
		avs_read && !ackQ && hitPage |=> avs_readdata[DATA_W-1:`PLDR_PAGE_W] == '0)
		else $error("page select upper bits not zero");

	a_len_resv: assert property (@(posedge core_clk) disable iff (rst) // R5
		avs_read && !ackQ && hitLen && diagOpen
		|=> avs_readdata[DATA_W-1:`PLDR_FIELD_W] == '0)
		else $error("length register upper bits not zero");

	a_len_ignore: assert property (@(posedge core_clk) disable iff (rst) // R3 R5
		accept && avs_write && hitLen |=> $stable(register_page_selector) && $stable(selCtrl))
		else $error("write to length register changed state");

	a_freq_resv: assert property (@(posedge core_clk) disable iff (rst) // R5
		avs_read && !ackQ && hitFreq && diagOpen
		|=> avs_readdata[`PLDR_BIT_SAMPLE-1:`PLDR_BIT_SELCTL+1] == '0)
		else $error("frequency reserved bits not zero");

	a_freq_field: assert property (@(posedge core_clk) disable iff (rst) // R9 R10
		avs_read && !ackQ && hitFreq && diagOpen
		|=> avs_readdata[`PLDR_FIELD_W-1:0] == $past(freqField))
		else $error("offset field read back wrong");

	a_freq_sel: assert property (@(posedge core_clk) disable iff (rst) // R7
		avs_read && !ackQ && hitFreq && diagOpen
		|=> avs_readdata[`PLDR_BIT_SELCTL] == $past(selCtrl))
		else $error("select bit read back wrong");

	a_sel_hold: assert property (@(posedge core_clk) disable iff (rst) // R7
		!(accept && avs_write && hitFreq && diagOpen && beHigh) |=> $stable(selCtrl))
		else $error("select bit changed without a write");

	a_closed_write: assert property (@(posedge core_clk) disable iff (rst) // R1
		accept && avs_write && hitFreq && !diagOpen |=> !dspReq && $stable(selCtrl))
		else $error("write acted on a closed diagnostics page");

	// cable length path
	a_len_pass: assert property (@(posedge core_clk) disable iff (rst) // R2 R3
		lenIn.speed100 && lenIn.linkUp && lenIn.lenValid
		|=> lenMeters == $past(lenIn.meters))
		else $error("valid length not passed through");

	a_len_slow: assert property (@(posedge core_clk) disable iff (rst) // R2 R4
		!lenIn.speed100 |=> lenMeters == `PLDR_LEN_UNKNOWN)
		else $error("length below 100 Mb/s not all-ones");

	a_len_novalid: assert property (@(posedge core_clk) disable iff (rst) // R4
		!lenIn.lenValid |=> lenMeters == `PLDR_LEN_UNKNOWN)
		else $error("undetermined length not all-ones");

	// sampler hand-off
	a_req_cause: assert property (@(posedge core_clk) disable iff (rst) // R12
		dspReq |-> $past(start))
		else $error("processor request without a sample write");

	a_req_gap: assert property (@(posedge core_clk) disable iff (rst) // R12
		dspReq |=> !dspReq ##1 !dspReq)
		else $error("processor requests too close together");

	a_req_busy: assert property (@(posedge core_clk) disable iff (rst) // R12
		dspReq |=> sampBusy)
		else $error("sampler idle right after a request");

	a_busy_drop: assert property (@(posedge core_clk) disable iff (rst) // R12
		accept && avs_write && hitFreq && beHigh && avs_writedata[`PLDR_BIT_SAMPLE]
		&& sampBusy |=> !dspReq)
		else $error("sample write taken while a sample was in flight");

	a_off_load: assert property (@(posedge core_clk) disable iff (rst) // R6 R9
		dspAck && sampBusy && !dspReq && !reqSel
		|=> freqField == $past(dspVal.offset))
		else $error("long-term offset not loaded");

	a_ctrl_load: assert property (@(posedge core_clk) disable iff (rst) // R7 R11
		dspAck && sampBusy && !dspReq && reqSel
		|=> freqField == 8'($past(dspVal.offset) + $past(dspVal.correction)))
		else $error("control value not loaded as offset plus correction");

	a_field_stand: assert property (@(posedge core_clk) disable iff (rst) // R12
		!(dspAck && sampBusy && !dspReq) |=> $stable(freqField))
		else $error("offset field changed without a completed request");
endmodule

// File: design/pldr_cfg.svh
// constants for the link diagnostics read-out registers
// Behaviour
// R1 - diagnostics page visible only when page bits equal 10
// R2 - length meaningful only at 100 Mb/s with link
// R3 - length in meters, read-only, bits 7:0
// R4 - undeterminable length reads as all-ones byte
// R5 - reserved bits ignore writes, read zero
// R6 - sample request with select zero fetches long-term offset
// R7 - sample request with select one fetches control value
// R8 - sample request bit always reads zero
// R9 - sampled value loads into offset field bits 7:0
// R10 - offset field is two's-complement, 0x7F..0x80
// R11 - control value equals offset plus phase correction
// R12 - one-cycle processor request; field holds until reload
`ifndef PLDR_CFG_SVH
`define PLDR_CFG_SVH

`define PLDR_IDX_LSB 2
`define PLDR_IDX_REGISTER_PAGE_SELECTOR 6'h13
`define PLDR_IDX_LEN 6'h14
`define PLDR_IDX_FREQ 6'h15
`define PLDR_PAGE_DIAG 2'h2
`define PLDR_PAGE_W 2
`define PLDR_BIT_SAMPLE 15
`define PLDR_BIT_SELCTL 8
`define PLDR_FIELD_W 8
`define PLDR_LEN_UNKNOWN 8'hFF
`define PLDR_RST_PAGE 2'h0
`define PLDR_RST_FIELD 8'h00
`define PLDR_BE_LOW 0
`define PLDR_BE_HIGH 1

`endif

// File: design/pldr_pkg.sv
// types shared by the link diagnostics read-out registers
package pldr_pkg;

	// cable length status from the receive path
	typedef struct packed {
		logic speed100;
		logic linkUp;
		logic lenValid;
		logic [7:0] meters;
	} pldr_len_s;

	// values answered by the signal processor
	typedef struct packed {
		logic [7:0] offset;
		logic [7:0] correction;
	} pldr_dsp_s;

	typedef enum logic [2:0] {
		PLDR_IDLE = 3'b001,
		PLDR_ASK = 3'b010,
		PLDR_WAIT = 3'b100
	} pldr_samp_e;

endpackage

// File: design/pldr_len_qual.sv
// cable length qualifier: passes the estimate only on a valid 100 Mb/s link
`include "pldr_cfg.svh"
module pldr_len_qual (
	input wire logic core_clk,
	input wire logic rst,
	input wire pldr_pkg::pldr_len_s lenIn,
	output logic [7:0] meters
);
	logic [7:0] next_meters;
	logic usable;

	always_comb begin
		usable = lenIn.speed100 && lenIn.linkUp && lenIn.lenValid; // R2
		next_meters = usable ? lenIn.meters : `PLDR_LEN_UNKNOWN; // R4
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meters <= `PLDR_RST_FIELD;
		end else begin
			meters <= next_meters; // R3
		end
	end

	a_len_unknown: assert property (@(posedge core_clk) disable iff (rst) // R4
		!(lenIn.speed100 && lenIn.linkUp) |=> meters == `PLDR_LEN_UNKNOWN)
		else $error("length not all-ones without 100 Mb/s link");
endmodule

// File: design/pldr_sample_ctrl.sv
// frequency offset sampler: one request to the signal processor per start
`include "pldr_cfg.svh"
module pldr_sample_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic selCtrl,
	input wire logic dspAck,
	input wire pldr_pkg::pldr_dsp_s dspVal,
	output logic dspReq,
	output logic busy,
	output logic [7:0] sample
);
	pldr_pkg::pldr_samp_e state;
	pldr_pkg::pldr_samp_e next_state;
	logic selQ;
	logic next_selQ;
	logic [7:0] next_sample;

	// request is a one-cycle pulse taken straight from the state
	assign dspReq = (state == pldr_pkg::PLDR_ASK); // R12
	assign busy = (state != pldr_pkg::PLDR_IDLE);

	always_comb begin
		next_state = state;
		next_selQ = selQ;
		next_sample = sample;
		case (state)
			pldr_pkg::PLDR_IDLE: begin
				if (start) begin
					next_selQ = selCtrl;
					next_state = pldr_pkg::PLDR_ASK;
				end
			end
			pldr_pkg::PLDR_ASK: begin
				next_state = pldr_pkg::PLDR_WAIT;
			end
			pldr_pkg::PLDR_WAIT: begin
				if (dspAck) begin
					// wraps like the processor's own 8-bit two's-complement sum
					next_sample = selQ ? 8'(dspVal.offset + dspVal.correction) // R7 R11
						: dspVal.offset; // R6
					next_state = pldr_pkg::PLDR_IDLE; // R9
				end
			end
			default: begin
				next_state = pldr_pkg::PLDR_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= pldr_pkg::PLDR_IDLE;
			selQ <= 1'b0;
			sample <= `PLDR_RST_FIELD;
		end else begin
			state <= next_state;
			selQ <= next_selQ;
			sample <= next_sample; // R10
		end
	end

	a_req_single: assert property (@(posedge core_clk) disable iff (rst) // R12
		dspReq |=> !dspReq)
		else $error("processor request longer than one cycle");

	a_hold_value: assert property (@(posedge core_clk) disable iff (rst) // R12
		!(state == pldr_pkg::PLDR_WAIT && dspAck) |=> sample == $past(sample))
		else $error("offset field changed without a completed request");
endmodule

// File: test/pldr_diag_regs_tb.sv
// self-checking bench for the link diagnostics read-out registers
module pldr_diag_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	pldr_pkg::pldr_len_s lenIn = '0;
	logic dspAck = 1'b0;
	pldr_pkg::pldr_dsp_s dspVal = '0;
	logic dspReq;
	pldr_pkg::pldr_dsp_s respVal = '0;
	int fails = 0;
	int n_checks = 0;
	int reqCount = 0;

	pldr_diag_regs u_pldr_diag_regs (
		.core_clk(core_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.lenIn(lenIn),
		.dspAck(dspAck),
		.dspVal(dspVal),
		.dspReq(dspReq)
	);

	initial begin
		forever #20 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// request held until the rising edge at which waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask

	// processor side: answers late so a read can land while the sample is pending
	always begin
		@(negedge core_clk);
		if (dspReq === 1'b1) begin
			reqCount++;
			@(negedge core_clk);
			chk({31'h0, dspReq}, 32'h0);
			repeat (8) @(posedge core_clk);
			dspAck <= 1'b1;
			dspVal <= respVal;
			@(posedge core_clk);
			dspAck <= 1'b0;
			dspVal <= ~respVal;
		end
	end

	task automatic t_reset;
		rdc(8'h4C, 32'h0);
		wr(8'h4C, 32'h2);
		rdc(8'h54, 32'h0);
		$display("t_reset done");
	endtask

	task automatic t_page;
		lenIn <= {3'b111, 8'h23};
		wr(8'h4C, 32'hFFFFFFFD);
		rdc(8'h4C, 32'h1);
		rdc(8'h50, 32'h0);
		wr(8'h4C, 32'h3);
		rdc(8'h54, 32'h0);
		wr(8'h4C, 32'h2);
		rdc(8'h50, 32'h23);
		rdc(8'h58, 32'h0);
		avs_byteenable <= 4'hE;
		wr(8'h4C, 32'h1);
		avs_byteenable <= 4'hF;
		rdc(8'h4C, 32'h2);
		$display("t_page done");
	endtask

	task automatic t_len;
		logic [2:0] bad [3] = '{3'b011, 3'b101, 3'b110};
		for (int i = 0; i < 3; i++) begin
			lenIn <= {bad[i], 8'h40};
			rdc(8'h50, 32'hFF);
		end
		lenIn <= {3'b111, 8'hC8};
		wr(8'h50, 32'h0000FF00);
		rdc(8'h50, 32'hC8);
		$display("t_len done");
	endtask

	// reserved bits 14:9 are written as ones and the read-only field as 5A to show they are ignored
	task automatic t_samp(input logic sel, input logic [7:0] off, input logic [7:0] cor,
			input logic [7:0] exp, input logic [7:0] prev);
		int r0;
		r0 = reqCount;
		respVal <= {off, cor};
		wr(8'h54, {16'h0, 1'b1, 6'h3F, sel, 8'h5A});
		rdc(8'h54, {23'h0, sel, prev});
		repeat (14) @(posedge core_clk);
		rdc(8'h54, {23'h0, sel, exp});
		chk(reqCount - r0, 32'h1);
		$display("t_samp done");
	endtask

	task automatic end_of_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		t_reset;
		t_page;
		t_len;
		t_samp(1'b0, 8'h7F, 8'h00, 8'h7F, 8'h00);
		t_samp(1'b0, 8'h80, 8'h11, 8'h80, 8'h7F);
		t_samp(1'b1, 8'h10, 8'hF5, 8'h05, 8'h80);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_reset;
		end_of_test;
	end

	initial begin
		repeat (3000) @(posedge core_clk);
		fails++;
		end_of_test;
	end
endmodule
